// [src/rtcc_cfg.svh]
// Register offsets, field positions, reset values and counts for the clock.
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

// ==========================================================================
// Register offsets
`define RTCC_ADDR_SEC    8'h00
`define RTCC_ADDR_YEAR   8'h05
`define RTCC_ADDR_WDAY   8'h06
`define RTCC_ADDR_SR     8'h07
`define RTCC_ADDR_INT    8'h08
`define RTCC_ADDR_ATR    8'h0a
`define RTCC_ADDR_DTR    8'h0b
`define RTCC_ADDR_ALM0   8'h0c
`define RTCC_ADDR_ALM5   8'h11

// ==========================================================================
// Status register fields
`define RTCC_SR_PLOSS    0
`define RTCC_SR_BAT      1
`define RTCC_SR_ALM      2
`define RTCC_SR_CLOCK_WRITE_ENABLE     4
`define RTCC_SR_EXTCLK   6
`define RTCC_SR_ACLR     7

// ==========================================================================
// Interrupt control fields
`define RTCC_INT_BKOUT   4
`define RTCC_INT_LBIAS   5
`define RTCC_INT_ALARM_FUNCTION_ENABLE    6
`define RTCC_INT_PERIOD  7

// ==========================================================================
// Reset values and counts
`define RTCC_INT_RST     8'h00
`define RTCC_ATR_RST     8'h00
`define RTCC_DTR_RST     3'h0
`define RTCC_ALM_RST     8'h00
`define RTCC_SEC_RST     8'h00
`define RTCC_SEC_LAST    8'h59
`define RTCC_DIV_TOP     16'h7fff

`endif

// [src/rtcc_device.sv]
// Control, status, trim and alarm logic of the calendar clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_cfg.svh"

module rtcc_device
   import rtcc_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   rtcc_link_if.dev        link,
   input  wire logic       xtal_tick_i,
   input  wire logic       osc_input_pin_i,
   input  wire logic       on_backup_i,
   input  wire rtcc_byte_t time_min_i,
   input  wire rtcc_byte_t time_hour_i,
   input  wire rtcc_byte_t time_date_i,
   input  wire rtcc_byte_t time_month_i,
   input  wire rtcc_byte_t time_year_i,
   input  wire rtcc_byte_t time_wday_i,
   output logic [7:0]      sec_o,
   output logic            sec_carry_o,
   output logic            cal_wr_o,
   output logic [2:0]      cal_addr_o,
   output logic [7:0]      cal_data_o,
   output logic            irq_n_o,
   output logic            osc_enable_o,
   output logic            low_bias_select_o,
   output logic [5:0]      load_cap_trim_o,
   output logic [1:0]      backup_trim_offset_o
);

   // =======================================================================
   // Helpers
   // Compares the value bits of one alarm byte with its time byte.
   function automatic logic byte_eq(input rtcc_byte_t a, input rtcc_byte_t t);
      byte_eq = (a[6:0] == t[6:0]);
   endfunction : byte_eq

   // =======================================================================
   // State
   logic       power_loss_flag_q;
   logic       backup_supply_flag_q;
   logic       alarm_flag_q;
   logic       clock_write_enable_q;
   logic       ext_clock_select_q;
   logic       auto_clear_enable_q;
   rtcc_byte_t irq_ctrl_q;
   rtcc_byte_t analog_trim_q;
   logic [2:0] digital_trim_q;
   rtcc_byte_t alarm_q [6];
   rtcc_byte_t sec_q;
   logic [15:0] div_q;
   logic       running_q;
   logic       pend_wr_q;
   logic [1:0] rd_snap_q;
   logic       eval_q;
   logic       match_prev_q;
   logic [14:0] fdiv_q;
   logic       pin_d1_q;
   logic       backup_d1_q;
   rtcc_byte_t rdata_q;
   logic       carry_q;
   logic       cal_wr_q;
   logic [2:0] cal_addr_q;
   rtcc_byte_t cal_data_q;
   logic       irq_n_q;

   // =======================================================================
   // Address decoding
   logic       sel_sr_w;
   logic       sel_int_w;
   logic       sel_atr_w;
   logic       sel_dtr_w;
   logic       sel_alm_w;
   logic       sel_clk_w;
   logic [2:0] alm_idx_w;
   logic       wr_clk_ok_w;
   logic       wr_sr_w;
   assign sel_sr_w    = (link.addr == `RTCC_ADDR_SR);
   assign sel_int_w   = (link.addr == `RTCC_ADDR_INT);
   assign sel_atr_w   = (link.addr == `RTCC_ADDR_ATR);
   assign sel_dtr_w   = (link.addr == `RTCC_ADDR_DTR);
   assign sel_alm_w   = (link.addr >= `RTCC_ADDR_ALM0) &&
                        (link.addr <= `RTCC_ADDR_ALM5);
   assign sel_clk_w   = (link.addr <= `RTCC_ADDR_WDAY);
   assign alm_idx_w   = 3'(link.addr - `RTCC_ADDR_ALM0);
   assign wr_clk_ok_w = link.wr && sel_clk_w && clock_write_enable_q;
   assign wr_sr_w     = link.wr && sel_sr_w;

   // =======================================================================
   // Oscillator source, divider and one-second tick
   logic        osc_tick_w;
   logic [15:0] div_top_w;
   logic        sec_tick_w;
   assign osc_tick_w = ext_clock_select_q ?
                       (osc_input_pin_i && !pin_d1_q) : xtal_tick_i;
   assign div_top_w  = `RTCC_DIV_TOP +
                       {{13{digital_trim_q[2]}}, digital_trim_q};
   assign sec_tick_w = running_q && osc_tick_w && (div_q == div_top_w);

   // Divider restarts at the STOP that closes a valid clock write.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q     <= 16'h0000;
         running_q <= 1'b0;
         pin_d1_q  <= 1'b0;
         fdiv_q    <= 15'h0000;
      end else begin
         pin_d1_q <= osc_input_pin_i;
         if (osc_tick_w) begin
            fdiv_q <= fdiv_q + 15'h0001;
         end
         if (link.stop && pend_wr_q) begin
            div_q     <= 16'h0000;
            running_q <= 1'b1;
         end else if (sec_tick_w) begin
            div_q <= 16'h0000;
         end else if (running_q && osc_tick_w) begin
            div_q <= div_q + 16'h0001;
         end
      end
   end

   // =======================================================================
   // Seconds counter in BCD
   rtcc_byte_t sec_inc_w;
   assign sec_inc_w = (sec_q[3:0] == 4'h9) ?
                      {sec_q[7:4] + 4'h1, 4'h0} : sec_q + 8'h01;

   // Writes win over a tick in the same cycle.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec_q   <= `RTCC_SEC_RST;
         carry_q <= 1'b0;
         eval_q  <= 1'b0;
      end else begin
         eval_q  <= sec_tick_w;
         carry_q <= sec_tick_w && (sec_q == `RTCC_SEC_LAST);
         if (wr_clk_ok_w && (link.addr == `RTCC_ADDR_SEC)) begin
            sec_q <= link.wdata;
         end else if (sec_tick_w) begin
            sec_q <= (sec_q == `RTCC_SEC_LAST) ? 8'h00 : sec_inc_w;
         end
      end
   end

   // Other calendar bytes are held by the calendar counter outside.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_wr_q   <= 1'b0;
         cal_addr_q <= 3'h0;
         cal_data_q <= 8'h00;
      end else begin
         cal_wr_q <= wr_clk_ok_w && (link.addr != `RTCC_ADDR_SEC);
         if (wr_clk_ok_w) begin
            cal_addr_q <= link.addr[2:0];
            cal_data_q <= link.wdata;
         end
      end
   end

   // =======================================================================
   // Alarm comparison
   rtcc_byte_t time_w [6];
   logic [5:0] alm_en_w;
   logic [5:0] alm_eq_w;
   logic       alarm_match_w;
   logic       alarm_evt_w;
   logic       freq_on_w;
   assign time_w[0] = sec_q;
   assign time_w[1] = time_min_i;
   assign time_w[2] = time_hour_i;
   assign time_w[3] = time_date_i;
   assign time_w[4] = time_month_i;
   assign time_w[5] = time_wday_i;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_cmp
         assign alm_en_w[gi] = alarm_q[gi][7];
         assign alm_eq_w[gi] = byte_eq(alarm_q[gi], time_w[gi]);
      end
   endgenerate

   assign freq_on_w     = (irq_ctrl_q[3:0] != 4'h0);
   assign alarm_match_w = (|alm_en_w) &&
                          ((alm_eq_w | ~alm_en_w) == 6'h3f);
   assign alarm_evt_w   = eval_q && alarm_match_w && !freq_on_w &&
                          irq_ctrl_q[`RTCC_INT_ALARM_FUNCTION_ENABLE] &&
                          (irq_ctrl_q[`RTCC_INT_PERIOD] ||
                           !match_prev_q);

   // =======================================================================
   // Status flags; a new event always wins over any clear.
   logic backup_rise_w;
   logic aclr_w;
   assign backup_rise_w = on_backup_i && !backup_d1_q;
   assign aclr_w        = link.stop && auto_clear_enable_q;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_loss_flag_q    <= 1'b1;
         backup_supply_flag_q <= 1'b0;
         alarm_flag_q         <= 1'b0;
         backup_d1_q          <= 1'b0;
         match_prev_q         <= 1'b0;
      end else begin
         backup_d1_q <= on_backup_i;
         if (eval_q) begin
            match_prev_q <= alarm_match_w;
         end
         if (link.stop && pend_wr_q) begin
            power_loss_flag_q <= 1'b0;
         end
         if (backup_rise_w) begin
            backup_supply_flag_q <= 1'b1;
         end else if (!on_backup_i &&
                      ((wr_sr_w && !link.wdata[`RTCC_SR_BAT]) ||
                       (aclr_w && rd_snap_q[1]))) begin
            backup_supply_flag_q <= 1'b0;
         end
         if (alarm_evt_w) begin
            alarm_flag_q <= 1'b1;
         end else if ((wr_sr_w && !link.wdata[`RTCC_SR_ALM]) ||
                      (aclr_w && rd_snap_q[0])) begin
            alarm_flag_q <= 1'b0;
         end
      end
   end

   // Tracks what a transaction read and whether it wrote the clock.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_wr_q <= 1'b0;
         rd_snap_q <= 2'b00;
      end else if (link.start || link.stop) begin
         pend_wr_q <= 1'b0;
         rd_snap_q <= 2'b00;
      end else begin
         if (wr_clk_ok_w) begin
            pend_wr_q <= 1'b1;
         end
         if (link.rd && sel_sr_w) begin
            rd_snap_q <= rd_snap_q |
                         {backup_supply_flag_q, alarm_flag_q};
         end
      end
   end

   // =======================================================================
   // Control, trim and alarm registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clock_write_enable_q <= 1'b0;
         ext_clock_select_q   <= 1'b0;
         auto_clear_enable_q  <= 1'b0;
         irq_ctrl_q           <= `RTCC_INT_RST;
         analog_trim_q        <= `RTCC_ATR_RST;
         digital_trim_q       <= `RTCC_DTR_RST;
         for (int i = 0; i < 6; i++) begin
            alarm_q[i] <= `RTCC_ALM_RST;
         end
      end else if (link.wr) begin
         if (sel_sr_w) begin
            clock_write_enable_q <= link.wdata[`RTCC_SR_CLOCK_WRITE_ENABLE];
            ext_clock_select_q   <= link.wdata[`RTCC_SR_EXTCLK];
            auto_clear_enable_q  <= link.wdata[`RTCC_SR_ACLR];
         end else if (sel_int_w) begin
            irq_ctrl_q <= link.wdata;
         end else if (sel_atr_w) begin
            analog_trim_q <= link.wdata;
         end else if (sel_dtr_w) begin
            digital_trim_q <= link.wdata[2:0];
         end else if (sel_alm_w) begin
            alarm_q[alm_idx_w] <= link.wdata;
         end
      end
   end

   // =======================================================================
   // Read data
   rtcc_byte_t sr_val_w;
   rtcc_byte_t rd_val_w;
   assign sr_val_w = {auto_clear_enable_q, ext_clock_select_q, 1'b0,
                      clock_write_enable_q, 1'b0, alarm_flag_q,
                      backup_supply_flag_q, power_loss_flag_q};
   assign rd_val_w = (link.addr == `RTCC_ADDR_SEC)  ? sec_q :
                     (link.addr == 8'h01)           ? time_min_i :
                     (link.addr == 8'h02)           ? time_hour_i :
                     (link.addr == 8'h03)           ? time_date_i :
                     (link.addr == 8'h04)           ? time_month_i :
                     (link.addr == `RTCC_ADDR_YEAR) ? time_year_i :
                     (link.addr == `RTCC_ADDR_WDAY) ? time_wday_i :
                     sel_sr_w  ? sr_val_w :
                     sel_int_w ? irq_ctrl_q :
                     sel_atr_w ? analog_trim_q :
                     sel_dtr_w ? {5'h00, digital_trim_q} :
                     sel_alm_w ? alarm_q[alm_idx_w] : 8'h00;

   // Read data is captured on the clock edge that ends the read strobe cycle.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (link.rd) begin
         rdata_q <= rd_val_w;
      end
   end

   // =======================================================================
   // Interrupt pin: frequency output or alarm, gated in backup.
   logic pin_w;
   assign pin_w = (on_backup_i && !irq_ctrl_q[`RTCC_INT_BKOUT]) ? 1'b1 :
                  freq_on_w ? fdiv_q[irq_ctrl_q[3:0] - 4'h1] :
                  !(alarm_flag_q && irq_ctrl_q[`RTCC_INT_ALARM_FUNCTION_ENABLE]);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= pin_w;
      end
   end

   // =======================================================================
   // Outputs
   assign link.rdata           = rdata_q;
   assign sec_o                = sec_q;
   assign sec_carry_o          = carry_q;
   assign cal_wr_o             = cal_wr_q;
   assign cal_addr_o           = cal_addr_q;
   assign cal_data_o           = cal_data_q;
   assign irq_n_o              = irq_n_q;
   assign osc_enable_o         = !ext_clock_select_q;
   assign low_bias_select_o    = irq_ctrl_q[`RTCC_INT_LBIAS];
   assign load_cap_trim_o      = analog_trim_q[5:0];
   assign backup_trim_offset_o = on_backup_i ?
                                 analog_trim_q[7:6] : 2'b00;

endmodule : rtcc_device

`default_nettype wire

// [src/rtcc_host.sv]
// Host end: turns single register commands into link transactions.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_cfg.svh"

module rtcc_host
   import rtcc_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   rtcc_link_if.host       link,
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_write_i,
   input  wire rtcc_byte_t cmd_addr_i,
   input  wire rtcc_byte_t cmd_data_i,
   output logic            cmd_ready_o,
   output logic            rsp_valid_o,
   output logic [7:0]      rsp_data_o
);

   // =======================================================================
   // State
   rtcc_host_state_t state_q;
   rtcc_host_state_t state_d;
   logic             write_q;
   rtcc_byte_t       addr_q;
   rtcc_byte_t       wdata_q;
   logic             rsp_valid_q;
   rtcc_byte_t       rsp_data_q;

   // Sequence: START, one byte, wait for read data if reading, STOP.
   always_comb begin
      state_d = state_q;
      case (state_q)
         RTCC_IDLE: begin
            if (cmd_valid_i) begin
               state_d = RTCC_START;
            end
         end
         RTCC_START: state_d = RTCC_XFER;
         RTCC_XFER:  state_d = write_q ? RTCC_STOP : RTCC_WAIT;
         RTCC_WAIT:  state_d = RTCC_STOP;
         RTCC_STOP:  state_d = RTCC_IDLE;
         default:    state_d = RTCC_IDLE;
      endcase
   end

   // Command capture and response registers.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q     <= RTCC_IDLE;
         write_q     <= 1'b0;
         addr_q      <= 8'h00;
         wdata_q     <= 8'h00;
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= 8'h00;
      end else begin
         state_q     <= state_d;
         rsp_valid_q <= (state_q == RTCC_WAIT);
         if (state_q == RTCC_IDLE && cmd_valid_i) begin
            write_q <= cmd_write_i;
            addr_q  <= cmd_addr_i;
            wdata_q <= cmd_data_i;
         end
         if (state_q == RTCC_WAIT) begin
            rsp_data_q <= link.rdata;
         end
      end
   end

   // =======================================================================
   // Link drive
   assign link.start  = (state_q == RTCC_START);
   assign link.wr     = (state_q == RTCC_XFER) && write_q;
   assign link.rd     = (state_q == RTCC_XFER) && !write_q;
   assign link.stop   = (state_q == RTCC_STOP);
   assign link.addr   = addr_q;
   assign link.wdata  = wdata_q;
   assign cmd_ready_o = (state_q == RTCC_IDLE);
   assign rsp_valid_o = rsp_valid_q;
   assign rsp_data_o  = rsp_data_q;

endmodule : rtcc_host

`default_nettype wire

// [src/rtcc_link_if.sv]
// Register link between the host and the clock block.
`timescale 1ns/1ps
`default_nettype none

interface rtcc_link_if;
   import rtcc_pkg::*;

   logic       start;
   logic       stop;
   logic       wr;
   logic       rd;
   rtcc_byte_t addr;
   rtcc_byte_t wdata;
   rtcc_byte_t rdata;

   modport dev  (input start, stop, wr, rd, addr, wdata, output rdata);
   modport host (output start, stop, wr, rd, addr, wdata, input rdata);
endinterface : rtcc_link_if

`default_nettype wire

// [src/rtcc_pkg.sv]
// Types shared by both ends of the clock register link.
package rtcc_pkg;

   typedef logic [7:0] rtcc_byte_t;

   typedef enum logic [2:0] {
      RTCC_IDLE,
      RTCC_START,
      RTCC_XFER,
      RTCC_WAIT,
      RTCC_STOP
   } rtcc_host_state_t;

endpackage : rtcc_pkg

// [test/rtcc_link_checker.sv]
// Link protocol and register readback checks for the clock block.
`timescale 1ns/1ps
`default_nettype none

module rtcc_link_checker
   import rtcc_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       rst_n_i,
   input wire logic       start,
   input wire logic       stop,
   input wire logic       wr,
   input wire logic       rd,
   input wire rtcc_byte_t addr,
   input wire rtcc_byte_t wdata,
   input wire rtcc_byte_t rdata
);
   // ==================================================================
   // Decode
   // Register groups touched by the current access.
   wire        alm_w   = addr >= 8'h0c && addr <= 8'h11;
   wire        keep_w  = addr == 8'h07 || addr == 8'h08 || addr == 8'h0a
                         || alm_w;
   wire        unmap_w = addr == 8'h09 || addr > 8'h11;
   rtcc_byte_t sh_q [0:31];

   // Shadow of the status, interrupt, analog trim and alarm bytes, so readback is judged without the device.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 32; i++) begin
            sh_q[i] <= 8'h00;
         end
      end else if (wr && keep_w) begin
         sh_q[addr[4:0]] <= wdata;
      end
   end

   // ==================================================================
   // Assertions
   // Every check samples on the clock and sleeps during reset.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   a_start_access: assert property (start |=> wr || rd)
      else $error("Start not followed by an access.");
   a_write_stop: assert property (wr |=> stop)
      else $error("Write not closed by stop.");
   a_read_stop: assert property (rd |=> !stop ##1 stop)
      else $error("Read not closed by stop after one wait.");
   a_rdata_holds: assert property (!rd |=> $stable(rdata))
      else $error("Read data moved without a read.");
   a_unmapped_zero: assert property (rd && unmap_w |=> rdata == 8'h00)
      else $error("Unmapped read returned data.");
   a_int_readback: assert property (rd && addr == 8'h08
      |=> rdata == sh_q[8]) else $error("Interrupt control readback bad.");
   a_trim_readback: assert property (rd && addr == 8'h0a
      |=> rdata == sh_q[10]) else $error("Analog trim readback bad.");
   a_alarm_readback: assert property (rd && alm_w
      |=> rdata == sh_q[$past(addr[4:0])])
      else $error("Alarm byte readback bad.");
   a_status_ctrl: assert property (rd && addr == 8'h07
      |=> {rdata[7:6], rdata[4]} == {sh_q[7][7:6], sh_q[7][4]})
      else $error("Status control bits readback bad.");

   c_status_write: cover property (wr && addr == 8'h07);
   c_alarm_read: cover property (rd && alm_w);
   c_unmapped_read: cover property (rd && unmap_w);
endmodule : rtcc_link_checker

`default_nettype wire

// [test/testbench.sv]
// Bench joining the host and clock ends over the register link.
`timescale 1ns/1ps
`default_nettype none

module testbench
   import rtcc_pkg::*;
;
   // One command: write data, or the byte a read must return.
   typedef struct {
      logic       w;
      rtcc_byte_t a;
      rtcc_byte_t d;
   } rtcc_row_t;

   logic       clock_i, rst_n_i, cmd_valid, cmd_write, tick_en, xtick;
   logic       osc_pin, on_backup, cmd_ready, rsp_valid, irq_n, osc_en;
   logic       low_bias, a, b, v, carry, cal_wr;
   logic [5:0] cap;
   logic [1:0] boff;
   logic [2:0] cal_addr;
   rtcc_byte_t cmd_addr, cmd_data, rsp_data, tmin, tzero, sec, q, cal_data;
   int         n_errors, comparisons, n_cyc, n_cal, n_carry;
   rtcc_row_t  rows [19] = '{
      '{1'h0, 8'h07, 8'h01}, '{1'h1, 8'h03, 8'h00}, '{1'h0, 8'h07, 8'h01},
      '{1'h1, 8'h08, 8'hc0}, '{1'h0, 8'h08, 8'hc0}, '{1'h1, 8'h0a, 8'he5},
      '{1'h0, 8'h0a, 8'he5}, '{1'h1, 8'h0b, 8'h04}, '{1'h0, 8'h0b, 8'h04},
      '{1'h0, 8'h09, 8'h00}, '{1'h1, 8'h12, 8'haa}, '{1'h0, 8'h12, 8'h00},
      '{1'h1, 8'h07, 8'h10}, '{1'h1, 8'h07, 8'h17}, '{1'h0, 8'h07, 8'h11},
      '{1'h1, 8'h00, 8'h59}, '{1'h0, 8'h07, 8'h10}, '{1'h1, 8'h0d, 8'h95},
      '{1'h0, 8'h0d, 8'h95}};

   // ==================================================================
   // Design and checker
   rtcc_link_if rtcc_link_if_inst ();

   rtcc_host rtcc_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .link(rtcc_link_if_inst), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
      .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
      .rsp_data_o(rsp_data));

   rtcc_device rtcc_device_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .link(rtcc_link_if_inst), .xtal_tick_i(xtick),
      .osc_input_pin_i(osc_pin), .on_backup_i(on_backup),
      .time_min_i(tmin), .time_hour_i(tzero), .time_date_i(tzero),
      .time_month_i(tzero), .time_year_i(tzero), .time_wday_i(tzero),
      .sec_o(sec), .sec_carry_o(carry), .cal_wr_o(cal_wr),
      .cal_addr_o(cal_addr), .cal_data_o(cal_data), .irq_n_o(irq_n),
      .osc_enable_o(osc_en),
      .low_bias_select_o(low_bias), .load_cap_trim_o(cap),
      .backup_trim_offset_o(boff));

   rtcc_link_checker rtcc_link_checker_inst (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .start(rtcc_link_if_inst.start),
      .stop(rtcc_link_if_inst.stop), .wr(rtcc_link_if_inst.wr),
      .rd(rtcc_link_if_inst.rd), .addr(rtcc_link_if_inst.addr),
      .wdata(rtcc_link_if_inst.wdata), .rdata(rtcc_link_if_inst.rdata));

   // ==================================================================
   // Tasks
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string n, input logic [7:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   // One host command; read data and its valid flag are taken while they
   // stand, one edge after the host registers them.
   task automatic xfer(input logic w, input rtcc_byte_t ad, d);
      @(posedge clock_i);
      cmd_valid <= 1'h1;
      cmd_write <= w;
      cmd_addr  <= ad;
      cmd_data  <= d;
      do @(posedge clock_i); while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
      repeat (4) @(posedge clock_i);
      q = rsp_data;
      v = rsp_valid;
      @(posedge clock_i);
   endtask : xfer

   // Reads one register and compares it.
   task automatic rdc(input rtcc_byte_t ad, e);
      xfer(1'h0, ad, 8'h00);
      chk("rdata", q, e);
   endtask : rdc

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // ==================================================================
   // Stimulus
   // Clock of 25 ns period.
   initial begin
      clock_i = 1'h0;
      forever #12.5 clock_i = ~clock_i;
   end

   // Crystal tick every second cycle and a toggling external clock pin.
   always @(posedge clock_i) begin
      xtick   <= tick_en && !xtick;
      osc_pin <= tick_en && !osc_pin;
   end

   // Counts calendar write pulses and seconds carries.
   always @(posedge clock_i) begin
      n_cal   <= n_cal + int'(cal_wr);
      n_carry <= n_carry + int'(carry);
   end

   // Cuts a hang short after the expected run length.
   initial begin
      repeat (95000) @(posedge clock_i);
      n_errors++;
      finish_test();
   end

   // Main sequence.
   initial begin
      {rst_n_i, cmd_valid, cmd_write, tick_en} = 4'h0;
      {on_backup, n_errors, comparisons} = '0;
      {cmd_addr, cmd_data, tzero, tmin} = 32'h0000_0015;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'h1;
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].d);
         chk("valid", {7'h0, v}, {7'h0, !rows[i].w});
         if (!rows[i].w) begin
            chk("rdata", q, rows[i].d);
         end
      end
      chk("cap", {2'h0, cap}, 8'h25);
      chk("boff", {6'h0, boff}, 8'h00);
      chk("sec", sec, 8'h59);
      xfer(1'h1, 8'h03, 8'h27);
      chk("cal_addr", {5'h0, cal_addr}, 8'h03);
      chk("cal_data", cal_data, 8'h27);
      chk("cal_wr", 8'(n_cal), 8'h01);
      $display("test register rows done");
      tick_en <= 1'h1;
      for (n_cyc = 0; n_cyc < 70000 && irq_n !== 1'h0; n_cyc++) begin
         @(posedge clock_i);
      end
      chk("irq", {7'h0, irq_n}, 8'h00);
      chk("period", {7'h0, n_cyc >= 65529 && n_cyc <= 65532}, 8'h01);
      chk("sec", sec, 8'h00);
      chk("carry", 8'(n_carry), 8'h01);
      rdc(8'h07, 8'h14);
      xfer(1'h1, 8'h07, 8'h10);
      chk("irq", {7'h0, irq_n}, 8'h01);
      rdc(8'h07, 8'h10);
      $display("test periodic alarm done");
      xfer(1'h1, 8'h08, 8'h41);
      @(negedge clock_i) a = irq_n;
      repeat (2) @(negedge clock_i);
      chk("freq_output", {7'h0, a ^ irq_n}, 8'h01);
      @(posedge clock_i) on_backup <= 1'h1;
      rdc(8'h07, 8'h12);
      @(negedge clock_i) a = irq_n;
      @(negedge clock_i) b = irq_n;
      chk("irq", {6'h0, a, b}, 8'h03);
      chk("boff", {6'h0, boff}, 8'h03);
      xfer(1'h1, 8'h07, 8'h10);
      rdc(8'h07, 8'h12);
      on_backup <= 1'h0;
      xfer(1'h1, 8'h07, 8'h90);
      rdc(8'h07, 8'h90);
      on_backup <= 1'h1;
      @(posedge clock_i) on_backup <= 1'h0;
      rdc(8'h07, 8'h92);
      rdc(8'h07, 8'h90);
      $display("test backup and auto clear done");
      xfer(1'h1, 8'h07, 8'hd0);
      chk("osc", {7'h0, osc_en}, 8'h00);
      xfer(1'h1, 8'h08, 8'h20);
      chk("bias", {7'h0, low_bias}, 8'h01);
      rst_n_i <= 1'h0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'h1;
      rdc(8'h07, 8'h01);
      chk("osc", {7'h0, osc_en}, 8'h01);
      $display("test controls and reset done");
      finish_test();
   end
endmodule : testbench

`default_nettype wire
